// File: verilog/acs_top.sv
// Coder capture block: sample port, simple ADPCM coder, framer and gated serial output
//
// Function
// - Two-bit method field selects basic, 24k, 32k or 40k coding.
// - Frame-mode bit one wraps output in frames; zero gives raw data.
// - Stereo bit on codes both channels; off codes one channel only.
// - Serial output delivers data only while its enable bit is set.
// - Clock polarity zero: data changes on rising edge; one: on falling.
// - Request polarity zero: valid while request high; one: while low.
// - Source bit set takes samples from sample port, else bitstream path.
// - With word position zero, alignment zero starts word at word-select edge; one offsets one bit.
// - Bit order zero shifts LSB first; one shifts MSB first.
// - Sample port captures on rising bit clock, or falling when polarity set.
// - Word-select polarity and start both set shift pairing by one word.
// - Frame length in bytes equals frame size times 90 plus 108.
// - Frame opens with five sync bytes, then 13 or 103 header bytes.
// - Word-length field is bits minus one; exactly that many captured.
// - Word-position field gives bit clocks ignored after word before boundary.
// - Coder pulse width is programmable by a seven-bit length field.
module acs_top
	import acs_pkg::*;
#(
	parameter logic [39:0] SYNC_WORD = 40'h0123456789 // Arbitrary value
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic ce,
	input wire logic soft_rst,
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr_en,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	input wire acs_adc_pins_t adc_pins,
	input wire acs_sample_t pcm_in,
	input wire logic pcm_in_valid,
	input wire logic out_serial_clock,
	output logic out_serial_line,
	output logic out_request,
	output logic coder_irq
);

	typedef enum logic [1:0] {ST_SYNC, ST_HDR, ST_DATA} acs_state_t;

	logic [7:0] cc_ff, en_ff, oc_ff, src_ff, pc_ff, fs_ff, irq_ff, wlen_ff, wpos_ff;

	// Register file; writes are masked, but software reset sets unused bit 0 of the interrupt config
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			cc_ff <= HRST_DEFAULT;
			en_ff <= HRST_DEFAULT;
			oc_ff <= HRST_DEFAULT;
			src_ff <= HRST_DEFAULT;
			pc_ff <= HRST_DEFAULT;
			fs_ff <= HRST_DEFAULT;
			irq_ff <= HRST_DEFAULT;
			wlen_ff <= HRST_WLEN;
			wpos_ff <= HRST_DEFAULT;
		end else if (ce) begin
			if (soft_rst) begin
				cc_ff <= SRST_DEFAULT;
				en_ff <= SRST_DEFAULT;
				oc_ff <= SRST_DEFAULT;
				src_ff <= SRST_DEFAULT;
				pc_ff <= SRST_DEFAULT;
				fs_ff <= SRST_FRAME_SIZE;
				irq_ff <= SRST_IRQ_CFG;
				wlen_ff <= SRST_WLEN;
				wpos_ff <= SRST_DEFAULT;
			end else if (reg_wr_en) begin
				case (reg_addr)
					OFS_CODER_CFG: cc_ff <= reg_wdata & MASK_CODER_CFG;
					OFS_OUT_EN: en_ff <= reg_wdata & MASK_BIT0;
					OFS_OUT_CFG: oc_ff <= reg_wdata & MASK_OUT_CFG;
					OFS_SRC_SEL: src_ff <= reg_wdata & MASK_BIT0;
					OFS_PORT_CFG: pc_ff <= reg_wdata & MASK_PORT_CFG;
					OFS_FRAME_SIZE: fs_ff <= reg_wdata & MASK_FULL;
					OFS_IRQ_CFG: irq_ff <= reg_wdata & MASK_IRQ_CFG;
					OFS_WLEN: wlen_ff <= reg_wdata & MASK_FIVE;
					OFS_WPOS: wpos_ff <= reg_wdata & MASK_FIVE;
					default: ;
				endcase
			end
		end
	end

	// Registered read data; unmapped offsets read zero
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			reg_rdata <= 8'h00;
		end else if (ce) begin
			case (reg_addr)
				OFS_CODER_CFG: reg_rdata <= cc_ff;
				OFS_OUT_EN: reg_rdata <= en_ff;
				OFS_OUT_CFG: reg_rdata <= oc_ff;
				OFS_SRC_SEL: reg_rdata <= src_ff;
				OFS_PORT_CFG: reg_rdata <= pc_ff;
				OFS_FRAME_SIZE: reg_rdata <= fs_ff;
				OFS_IRQ_CFG: reg_rdata <= irq_ff;
				OFS_WLEN: reg_rdata <= wlen_ff;
				OFS_WPOS: reg_rdata <= wpos_ff;
				default: reg_rdata <= 8'h00;
			endcase
		end
	end

	// Decoded settings
	acs_algo_t algo;
	logic framed, stereo, run, src_adc;
	logic [2:0] code_w;
	logic [15:0] frame_len, hdr_end;
	assign algo = acs_algo_t'(cc_ff[CC_ALGO_LSB +: 2]);
	assign framed = cc_ff[CC_FRAMED_BIT];
	assign stereo = cc_ff[CC_STEREO_BIT];
	assign run = en_ff[EN_BIT];
	assign src_adc = src_ff[EN_BIT];
	assign frame_len = {8'h00, fs_ff} * FRAME_MULT + FRAME_BASE;
	assign hdr_end = SYNC_LEN + ((algo == ALGO_BASIC) ? HDR_LEN_BASIC : HDR_LEN_G726);

	always_comb begin
		unique case (algo)
			ALGO_BASIC: code_w = CODE_W_BASIC;
			ALGO_24K: code_w = CODE_W_24K;
			ALGO_32K: code_w = CODE_W_32K;
			ALGO_40K: code_w = CODE_W_40K;
		endcase
	end

	// Sample port pins come from another clock: two flops first
	acs_adc_pins_t adc_s;
	acs_sync #(.W(3)) u_adc_sync (
		.clk(mclk),
		.rst(rst),
		.ce(ce),
		.d(adc_pins),
		.q(adc_s)
	);

	logic bclk_d_ff, lrck_d_ff, cap_edge, ws_edge, in_word, word_last, adc_done_ff, pair_ph_ff;
	logic [5:0] bit_idx_ff, slot_len_ff, idx_now, start_bit, word_off;
	logic [31:0] word_ff, nxt_word;

	// Capture edge follows the clock polarity bit
	assign cap_edge = pc_ff[PC_CLKPOL_BIT] ? (bclk_d_ff & ~adc_s.bclk) : (~bclk_d_ff & adc_s.bclk);
	assign ws_edge = adc_s.lrck != lrck_d_ff;
	assign idx_now = ws_edge ? 6'h00 : 6'(bit_idx_ff + 6'h01);
	// Left-justified by default; a nonzero position right-justifies against the last slot length
	assign start_bit = (wpos_ff == 8'h00) ? {5'h00, pc_ff[PC_ALIGN_BIT]} :
		6'(slot_len_ff - wpos_ff[5:0] - wlen_ff[5:0] - 6'h01);
	assign word_off = 6'(idx_now - start_bit);
	assign in_word = (idx_now >= start_bit) && (word_off <= wlen_ff[5:0]);
	assign word_last = in_word && (word_off == wlen_ff[5:0]);

	always_comb begin
		nxt_word = (word_off == 6'h00) ? 32'h00000000 : word_ff;
		if (pc_ff[PC_ORDER_BIT]) begin
			nxt_word = {nxt_word[30:0], adc_s.data};
		end else begin
			nxt_word[word_off[4:0]] = adc_s.data;
		end
	end

	// Bit counting and word assembly on the selected bit clock edge
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			bclk_d_ff <= 1'b0;
			lrck_d_ff <= 1'b0;
			bit_idx_ff <= 6'h00;
			slot_len_ff <= 6'h00;
			word_ff <= 32'h00000000;
			adc_done_ff <= 1'b0;
		end else if (ce) begin
			bclk_d_ff <= adc_s.bclk;
			adc_done_ff <= 1'b0;
			if (cap_edge) begin
				lrck_d_ff <= adc_s.lrck;
				bit_idx_ff <= idx_now;
				if (ws_edge) begin
					slot_len_ff <= 6'(bit_idx_ff + 6'h01);
				end
				if (in_word) begin
					word_ff <= nxt_word;
					adc_done_ff <= word_last;
				end
			end
		end
	end

	// Left/right pairing phase; both pairing bits set take the first word as right
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			pair_ph_ff <= 1'b0;
		end else if (ce) begin
			if (!src_adc || !run) begin
				pair_ph_ff <= pc_ff[PC_WSPOL_BIT] & pc_ff[PC_WSSTART_BIT];
			end else if (adc_done_ff) begin
				pair_ph_ff <= ~pair_ph_ff;
			end
		end
	end

	// Sample selection; word is MSB-aligned to 16 bits
	logic [31:0] adc_aligned;
	logic smp_valid, smp_right;
	logic [15:0] smp_data;
	assign adc_aligned = word_ff << (5'h1f - wlen_ff[4:0]);
	assign smp_valid = src_adc ? adc_done_ff : pcm_in_valid;
	assign smp_right = src_adc ? pair_ph_ff : pcm_in.right;
	assign smp_data = src_adc ? adc_aligned[31:16] : pcm_in.data;

	// Differential coder with fixed step per method; mono ignores right samples
	logic signed [15:0] pred_ff [2];
	logic signed [16:0] diff, q, sum;
	logic [4:0] code_sh, code_bits;
	logic [5:0] code_mask;
	logic [15:0] acc_ff, acc_add;
	logic [4:0] accn_ff;
	logic take, emit;
	assign code_sh = 5'h11 - {2'h0, code_w};
	assign diff = $signed({smp_data[15], smp_data}) - $signed({pred_ff[smp_right][15], pred_ff[smp_right]});
	assign q = diff >>> code_sh;
	assign sum = $signed({pred_ff[smp_right][15], pred_ff[smp_right]}) + (q <<< code_sh);
	assign code_mask = 6'(6'h01 << code_w) - 6'h01;
	assign code_bits = q[4:0] & code_mask[4:0];
	assign take = run && smp_valid && (stereo || !smp_right) && (accn_ff < 5'h08);
	assign acc_add = {11'h000, code_bits} << accn_ff;

	// Predictor per channel, saturated to 16 bits
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			pred_ff[0] <= 16'sh0000;
			pred_ff[1] <= 16'sh0000;
		end else if (ce) begin
			if (!run) begin
				pred_ff[0] <= 16'sh0000;
				pred_ff[1] <= 16'sh0000;
			end else if (take) begin
				if (sum[16] != sum[15]) begin
					pred_ff[smp_right] <= sum[16] ? 16'sh8000 : 16'sh7fff;
				end else begin
					pred_ff[smp_right] <= sum[15:0];
				end
			end
		end
	end

	// Code packer: codes fill LSB first, bytes leave from the bottom
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			acc_ff <= 16'h0000;
			accn_ff <= 5'h00;
		end else if (ce) begin
			if (!run) begin
				acc_ff <= 16'h0000;
				accn_ff <= 5'h00;
			end else begin
				acc_ff <= ((emit ? (acc_ff >> 8) : acc_ff) | (take ? (acc_add >> (emit ? 8 : 0)) : 16'h0000));
				accn_ff <= 5'(accn_ff + (take ? {2'h0, code_w} : 5'h00) - (emit ? 5'h08 : 5'h00));
			end
		end
	end

	// Byte handshake toward the link domain
	logic req_tgl_ff, ack_s, pend, launch;
	logic [7:0] byte_ff, nxt_byte;
	acs_state_t state_ff;
	logic [15:0] cnt_ff;
	logic [6:0] irq_cnt_ff;
	assign pend = req_tgl_ff != ack_s;
	assign launch = run && !pend && ((state_ff != ST_DATA) || (accn_ff >= 5'h08));
	assign emit = launch && (state_ff == ST_DATA);

	always_comb begin
		unique case (state_ff)
			ST_SYNC: nxt_byte = 8'(SYNC_WORD >> (6'(SYNC_LEN - 16'h0001 - cnt_ff) * 8));
			ST_HDR: nxt_byte = (cnt_ff == SYNC_LEN) ? cc_ff : ((cnt_ff == SYNC_LEN + 16'h0001) ? fs_ff : 8'h00);
			ST_DATA: nxt_byte = acc_ff[7:0];
		endcase
	end

	// Framer: sync, header, payload; raw mode stays in payload
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			state_ff <= ST_SYNC;
			cnt_ff <= 16'h0000;
			byte_ff <= 8'h00;
			req_tgl_ff <= 1'b0;
		end else if (ce) begin
			if (!run) begin
				state_ff <= framed ? ST_SYNC : ST_DATA;
				cnt_ff <= 16'h0000;
				req_tgl_ff <= ack_s; // Abandon an unsent byte
			end else if (!framed) begin
				state_ff <= ST_DATA;
				cnt_ff <= 16'h0000;
				if (launch) begin
					byte_ff <= nxt_byte;
					req_tgl_ff <= ~req_tgl_ff;
				end
			end else if (launch) begin
				byte_ff <= nxt_byte;
				req_tgl_ff <= ~req_tgl_ff;
				cnt_ff <= 16'(cnt_ff + 16'h0001);
				if (cnt_ff == 16'(frame_len - 16'h0001)) begin
					state_ff <= ST_SYNC;
					cnt_ff <= 16'h0000;
				end else if (cnt_ff == 16'(SYNC_LEN - 16'h0001)) begin
					state_ff <= ST_HDR;
				end else if (cnt_ff == 16'(hdr_end - 16'h0001)) begin
					state_ff <= ST_DATA;
				end
			end
		end
	end

	// Frame-done pulse lasting the programmed number of system clocks
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			irq_cnt_ff <= 7'h00;
		end else if (ce) begin
			if (run && framed && launch && (cnt_ff == 16'(frame_len - 16'h0001))) begin
				irq_cnt_ff <= irq_ff[IRQ_LEN_LSB +: 7];
			end else if (irq_cnt_ff != 7'h00) begin
				irq_cnt_ff <= 7'(irq_cnt_ff - 7'h01);
			end
		end
	end
	assign coder_irq = irq_cnt_ff != 7'h00;

	// Link side runs on the host clock; polarity picks the launching edge
	logic link_clk, en_l, req_l, ack_tgl_ff, busy_ff;
	logic [7:0] sh_ff;
	logic [2:0] bit_ff;
	assign link_clk = out_serial_clock ^ oc_ff[OC_CLKPOL_BIT];

	acs_sync #(.W(2)) u_link_sync (
		.clk(link_clk),
		.rst(rst),
		.ce(1'b1),
		.d({run, req_tgl_ff}),
		.q({en_l, req_l})
	);

	acs_sync #(.W(1)) u_ack_sync (
		.clk(mclk),
		.rst(rst),
		.ce(ce),
		.d(ack_tgl_ff),
		.q(ack_s)
	);

	// Shifter: byte_ff is stable while the request toggle is outstanding
	always_ff @(posedge link_clk or posedge rst) begin
		if (rst) begin
			ack_tgl_ff <= 1'b0;
			busy_ff <= 1'b0;
			sh_ff <= 8'h00;
			bit_ff <= 3'h0;
		end else if (!en_l) begin
			busy_ff <= 1'b0;
			sh_ff <= 8'h00;
			ack_tgl_ff <= req_l;
		end else if ((!busy_ff || bit_ff == 3'h7) && (req_l != ack_tgl_ff)) begin
			sh_ff <= byte_ff;
			ack_tgl_ff <= req_l;
			busy_ff <= 1'b1;
			bit_ff <= 3'h0;
		end else if (busy_ff && bit_ff == 3'h7) begin
			busy_ff <= 1'b0;
			sh_ff <= 8'h00;
		end else if (busy_ff) begin
			sh_ff <= {sh_ff[6:0], 1'b0};
			bit_ff <= 3'(bit_ff + 3'h1);
		end
	end

	assign out_serial_line = sh_ff[7];
	// Request marks valid bits at the chosen level; config must be static while enabled
	assign out_request = busy_ff ^ oc_ff[OC_REQPOL_BIT];

endmodule

// File: shared/acs_pkg.sv
// Package: register map, field layout, reset values and carriers for the coder capture block
package acs_pkg;

	// Register offsets on the control port
	localparam logic [7:0] OFS_CODER_CFG = 8'hb8;
	localparam logic [7:0] OFS_OUT_EN = 8'hb9;
	localparam logic [7:0] OFS_OUT_CFG = 8'hba;
	localparam logic [7:0] OFS_SRC_SEL = 8'hbb;
	localparam logic [7:0] OFS_PORT_CFG = 8'hbc;
	localparam logic [7:0] OFS_FRAME_SIZE = 8'hbd;
	localparam logic [7:0] OFS_IRQ_CFG = 8'hbe;
	localparam logic [7:0] OFS_WLEN = 8'hc0;
	localparam logic [7:0] OFS_WPOS = 8'hc1;

	// Hardware reset values
	localparam logic [7:0] HRST_DEFAULT = 8'h00;
	localparam logic [7:0] HRST_WLEN = 8'h0f;

	// Software reset values
	localparam logic [7:0] SRST_DEFAULT = 8'h00;
	localparam logic [7:0] SRST_FRAME_SIZE = 8'h13;
	localparam logic [7:0] SRST_IRQ_CFG = 8'h0b;
	localparam logic [7:0] SRST_WLEN = 8'h0f;

	// Implemented bits of each register; the rest read zero, except bit 0 of the interrupt config after software reset
	localparam logic [7:0] MASK_CODER_CFG = 8'h0f;
	localparam logic [7:0] MASK_BIT0 = 8'h01;
	localparam logic [7:0] MASK_OUT_CFG = 8'h03;
	localparam logic [7:0] MASK_PORT_CFG = 8'h1f;
	localparam logic [7:0] MASK_FULL = 8'hff;
	localparam logic [7:0] MASK_IRQ_CFG = 8'hfe;
	localparam logic [7:0] MASK_FIVE = 8'h1f;

	// Field positions
	localparam int CC_FRAMED_BIT = 0;
	localparam int CC_STEREO_BIT = 1;
	localparam int CC_ALGO_LSB = 2;
	localparam int OC_CLKPOL_BIT = 0;
	localparam int OC_REQPOL_BIT = 1;
	localparam int EN_BIT = 0;
	localparam int PC_ALIGN_BIT = 0;
	localparam int PC_ORDER_BIT = 1;
	localparam int PC_CLKPOL_BIT = 2;
	localparam int PC_WSPOL_BIT = 3;
	localparam int PC_WSSTART_BIT = 4;
	localparam int IRQ_LEN_LSB = 1;

	// Frame geometry in bytes
	localparam logic [15:0] FRAME_MULT = 16'h005a;
	localparam logic [15:0] FRAME_BASE = 16'h006c;
	localparam logic [15:0] SYNC_LEN = 16'h0005;
	localparam logic [15:0] HDR_LEN_BASIC = 16'h000d;
	localparam logic [15:0] HDR_LEN_G726 = 16'h0067;

	// Code bits per sample for each method
	localparam logic [2:0] CODE_W_BASIC = 3'h4;
	localparam logic [2:0] CODE_W_24K = 3'h3;
	localparam logic [2:0] CODE_W_32K = 3'h4;
	localparam logic [2:0] CODE_W_40K = 3'h5;

	typedef enum logic [1:0] {ALGO_BASIC, ALGO_24K, ALGO_32K, ALGO_40K} acs_algo_t;

	// Serial sample port pins
	typedef struct packed {
		logic bclk;
		logic lrck;
		logic data;
	} acs_adc_pins_t;

	// One PCM sample with its channel
	typedef struct packed {
		logic right;
		logic [15:0] data;
	} acs_sample_t;

endpackage

// File: verilog/acs_sync.sv
// Two flip-flop synchroniser for a group of level signals
module acs_sync #(
	parameter int W = 1
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);

	logic [W-1:0] meta_ff;

	// First stage feeds only the second stage
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			meta_ff <= '0;
			q <= '0;
		end else if (ce) begin
			meta_ff <= d;
			q <= meta_ff;
		end
	end

endmodule

// File: bench/acs_assertions.sv
// Checker for the coder capture block, bound to its top module
module acs_checker
	import acs_pkg::*;
(
	input wire logic mclk,
	input wire logic rst,
	input wire logic ce,
	input wire logic soft_rst,
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr_en,
	input wire logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata,
	input wire acs_adc_pins_t adc_pins,
	input wire acs_sample_t pcm_in,
	input wire logic pcm_in_valid,
	input wire logic out_serial_clock,
	input wire logic out_serial_line,
	input wire logic out_request,
	input wire logic coder_irq
);
	logic pol_ff;
	logic en_ff;
	logic [7:0] off_cnt_ff;
	logic [7:0] irq_cnt_ff;
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);

	function automatic logic is_mapped(input logic [7:0] a);
		return (a >= OFS_CODER_CFG && a <= OFS_IRQ_CFG) || a == OFS_WLEN || a == OFS_WPOS;
	endfunction

	// Mirror of enable and request polarity, so idle level is known here
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			pol_ff <= 1'b0;
			en_ff <= 1'b0;
		end else if (ce && soft_rst) begin
			pol_ff <= 1'b0;
			en_ff <= 1'b0;
		end else if (ce && reg_wr_en) begin
			if (reg_addr == OFS_OUT_CFG)
				pol_ff <= reg_wdata[OC_REQPOL_BIT];
			if (reg_addr == OFS_OUT_EN)
				en_ff <= reg_wdata[EN_BIT];
		end
	end

	// Cycles since disable; saturates so it never wraps back to the check point
	always_ff @(posedge mclk or posedge rst) begin
		if (rst)
			off_cnt_ff <= 8'h00;
		else if (en_ff)
			off_cnt_ff <= 8'h00;
		else if (off_cnt_ff != 8'hff)
			off_cnt_ff <= off_cnt_ff + 8'h01;
	end

	// Length of the current pulse on the coder line
	always_ff @(posedge mclk or posedge rst) begin
		if (rst)
			irq_cnt_ff <= 8'h00;
		else if (coder_irq && irq_cnt_ff != 8'hff)
			irq_cnt_ff <= irq_cnt_ff + 8'h01;
		else if (!coder_irq)
			irq_cnt_ff <= 8'h00;
	end

	a_unmapped_zero: assert property (ce && !is_mapped(reg_addr) |=> reg_rdata == 8'h00)
		else $error("unmapped read not zero");
	a_coder_unused: assert property (reg_addr == OFS_CODER_CFG |=> (reg_rdata & ~MASK_CODER_CFG) == 8'h00)
		else $error("coder config unused bits set");
	a_wlen_width: assert property (reg_addr == OFS_WLEN |=> reg_rdata[7:5] == 3'h0)
		else $error("word length wider than five bits");
	a_wpos_width: assert property (reg_addr == OFS_WPOS |=> reg_rdata[7:5] == 3'h0)
		else $error("word position wider than five bits");
	a_size_write: assert property (reg_wr_en && reg_addr == OFS_FRAME_SIZE && !soft_rst ##1
		(reg_addr == OFS_FRAME_SIZE && !reg_wr_en && !soft_rst) |=> reg_rdata == $past(reg_wdata, 2))
		else $error("frame size readback differs");
	a_line_idle: assert property (out_request == pol_ff |-> !out_serial_line)
		else $error("data line busy while request idle");
	a_disable_quiet: assert property (off_cnt_ff == 8'd30 |-> out_request == pol_ff && !out_serial_line)
		else $error("output active while disabled");
	a_irq_bound: assert property (coder_irq |-> irq_cnt_ff <= 8'd127)
		else $error("coder pulse too long");

	c_request: cover property (out_request != pol_ff);
	c_irq: cover property (coder_irq);
	c_inverted_idle: cover property (off_cnt_ff == 8'd30 && pol_ff);
endmodule

bind acs_top acs_checker u_acs_checker (.mclk(mclk), .rst(rst), .ce(ce), .soft_rst(soft_rst),
	.reg_addr(reg_addr), .reg_wr_en(reg_wr_en), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
	.adc_pins(adc_pins), .pcm_in(pcm_in), .pcm_in_valid(pcm_in_valid), .out_serial_clock(out_serial_clock),
	.out_serial_line(out_serial_line), .out_request(out_request), .coder_irq(coder_irq));

// File: bench/acs_host_model.sv
// Host model: makes the link clock and collects coded bytes
module acs_host_model (
	input wire logic run,
	input wire logic clk_pol,
	input wire logic req_pol,
	input wire logic out_serial_line,
	input wire logic out_request,
	output logic out_serial_clock
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [7:0] rx_mem [256];
	logic [7:0] sh;
	int rx_cnt;
	int bits;

	// Clock stands still at zero while no transfer is wanted
	initial begin
		out_serial_clock = 1'b0;
		rx_cnt = 0;
		bits = 0;
		#1.7;
		forever #3 out_serial_clock = run ? ~out_serial_clock : 1'b0;
	end

	// Sample on the edge opposite to the launch edge, MSB first
	always @(out_serial_clock) begin
		if ((out_serial_clock ^ clk_pol) == 1'b0) begin
			if (out_request !== req_pol) begin
				sh = {sh[6:0], out_serial_line};
				bits++;
				if (bits == 8) begin
					rx_mem[rx_cnt[7:0]] = sh;
					rx_cnt++;
					bits = 0;
				end
			end else
				bits = 0;
		end
	end
endmodule

// File: bench/tb_adpcm_capture_serial_out.sv
// Testbench for the coder capture block
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin error_cnt++; \
	$display("wrong value at %0t: got %h exp %h", $time, (a), (e)); end end
module tb_adpcm_capture_serial_out
	import acs_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	localparam logic [39:0] SYNC = 40'h0123456789; // Arbitrary value
	localparam logic [7:0] OFS [6] = '{OFS_CODER_CFG, OFS_OUT_EN, OFS_OUT_CFG, OFS_SRC_SEL, OFS_PORT_CFG, OFS_FRAME_SIZE};
	localparam logic [7:0] MSK [6] = '{MASK_CODER_CFG, MASK_BIT0, MASK_OUT_CFG, MASK_BIT0, MASK_PORT_CFG, MASK_FULL};
	logic mclk, rst, soft_rst, reg_wr_en, pcm_in_valid, run, cp, rp, feed;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, rd, cnt;
	acs_adc_pins_t adc_pins;
	acs_sample_t pcm_in;
	wire out_serial_clock, out_serial_line, out_request, coder_irq;
	int error_cnt, samples_checked;

	acs_top #(.SYNC_WORD(SYNC)) u_acs_top (.mclk(mclk), .rst(rst), .ce(1'b1), .soft_rst(soft_rst),
		.reg_addr(reg_addr), .reg_wr_en(reg_wr_en), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.adc_pins(adc_pins), .pcm_in(pcm_in), .pcm_in_valid(pcm_in_valid),
		.out_serial_clock(out_serial_clock), .out_serial_line(out_serial_line),
		.out_request(out_request), .coder_irq(coder_irq));
	acs_host_model u_acs_host_model (.run(run), .clk_pol(cp), .req_pol(rp), .out_serial_line(out_serial_line),
		.out_request(out_request), .out_serial_clock(out_serial_clock));

	initial begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end

	// Bitstream samples every third cycle; extra pulses while busy are simply dropped
	always @(negedge mclk) begin
		cnt <= cnt + 8'h01;
		pcm_in_valid <= feed && (cnt % 3 == 0);
		pcm_in.data <= {cnt, ~cnt};
		if (pcm_in_valid)
			pcm_in.right <= ~pcm_in.right;
	end

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge mclk);
		reg_addr = a;
		reg_wdata = d;
		reg_wr_en = 1'b1;
		@(negedge mclk);
		reg_wr_en = 1'b0;
	endtask

	task automatic rdb(input logic [7:0] a);
		@(negedge mclk);
		reg_addr = a;
		@(negedge mclk);
		rd = reg_rdata;
	endtask

	// Reset values, implemented bits, unmapped place and software reset
	task automatic t_regs();
		for (int i = 0; i < 6; i++) begin
			rdb(OFS[i]);
			`CHK(rd, 8'h00)
			wr(OFS[i], 8'hff);
			rdb(OFS[i]);
			`CHK(rd, MSK[i])
		end
		rdb(OFS_WLEN);
		`CHK(rd, HRST_WLEN)
		rdb(OFS_WPOS);
		`CHK(rd, 8'h00)
		wr(8'hb7, 8'hff);
		rdb(8'hb7);
		`CHK(rd, 8'h00)
		@(negedge mclk);
		soft_rst = 1'b1;
		@(negedge mclk);
		soft_rst = 1'b0;
		rdb(OFS_FRAME_SIZE);
		`CHK(rd, SRST_FRAME_SIZE)
	endtask

	// One coded run through the link; checks sync, header and frame length
	task automatic t_frame(input logic [1:0] algo, input logic fr, input logic c, input logic r);
		int n, hl, miss, irq_hi;
		logic [7:0] cfg;
		cfg = {4'h0, algo, c, fr};
		n = fr ? 113 : 8;
		hl = (algo == 2'b00) ? 13 : 103;
		miss = 0;
		irq_hi = 0;
		cp = c;
		rp = r;
		wr(OFS_OUT_CFG, {6'h00, r, c});
		wr(OFS_CODER_CFG, cfg);
		wr(OFS_FRAME_SIZE, 8'h00);
		u_acs_host_model.rx_cnt = 0;
		run = 1'b1;
		feed = 1'b1;
		wr(OFS_OUT_EN, 8'h01);
		// Count cycles of the frame-done pulse; one frame ends inside this window when framed
		for (int k = 0; k < 10000 && u_acs_host_model.rx_cnt < n; k++) begin
			@(negedge mclk);
			if (coder_irq === 1'b1)
				irq_hi++;
		end
		`CHK(irq_hi, fr ? int'(SRST_IRQ_CFG >> IRQ_LEN_LSB) : 0)
		wr(OFS_OUT_EN, 8'h00);
		repeat (40) @(negedge mclk);
		`CHK(out_request, r)
		run = 1'b0;
		feed = 1'b0;
		`CHK(u_acs_host_model.rx_cnt >= n, 1'b1)
		for (int k = 0; k < 5; k++)
			if (u_acs_host_model.rx_mem[k] !== SYNC[39 - 8 * k -: 8])
				miss++;
		`CHK(miss == 0, fr)
		if (fr) begin
			`CHK(u_acs_host_model.rx_mem[5], cfg)
			for (int k = 7; k < 5 + hl; k++)
				`CHK(u_acs_host_model.rx_mem[k], 8'h00)
			for (int k = 0; k < 5; k++)
				`CHK(u_acs_host_model.rx_mem[108 + k], SYNC[39 - 8 * k -: 8])
		end
	endtask

	task automatic end_of_test();
		$display("errors %0d checks %0d", error_cnt, samples_checked);
		if (error_cnt == 0 && samples_checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	initial begin
		{rst, soft_rst, reg_wr_en, pcm_in_valid, run, cp, rp, feed} = 8'hff;
		{soft_rst, reg_wr_en, pcm_in_valid, run, cp, rp, feed} = 7'h00;
		{reg_addr, reg_wdata, cnt} = 24'h000000;
		adc_pins = '0;
		pcm_in = '0;
		error_cnt = 0;
		samples_checked = 0;
		repeat (12) @(posedge mclk);
		@(negedge mclk);
		rst = 1'b0;
		t_regs();
		t_frame(2'b00, 1'b1, 1'b0, 1'b0);
		t_frame(2'b01, 1'b1, 1'b1, 1'b0);
		t_frame(2'b10, 1'b1, 1'b0, 1'b1);
		t_frame(2'b11, 1'b1, 1'b1, 1'b1);
		t_frame(2'b00, 1'b0, 1'b0, 1'b0);
		end_of_test();
	end

	// Five runs take well under this span
	initial begin
		#1900us;
		error_cnt++;
		end_of_test();
	end
endmodule
